// [pkg/ppc_pkg.sv]
package ppc_pkg;

  // Port geometry
  localparam int NUM_PORTS = 5;
  localparam int PORT_W    = 8;
  localparam int PIN_W     = NUM_PORTS * PORT_W;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_PAD      = 12'hF3C;
  localparam logic [11:0] IDX_OD_SPI   = 12'hF40;
  localparam logic [11:0] IDX_OD_SER   = 12'hF41;
  localparam logic [11:0] IDX_OD_CAP   = 12'hF42;
  localparam logic [11:0] IDX_PIN_BASE = 12'hF80;
  localparam logic [11:0] IDX_LAT_BASE = 12'hF89;
  localparam logic [11:0] IDX_DIR_BASE = 12'hF92;

  // Field positions
  localparam int PAD_TTL_BIT  = 0;
  localparam int CLK_SEL_LSB  = 1;
  localparam int CLK_SEL_MSB  = 2;
  localparam int OD_MOD1_BIT  = 0;
  localparam int OD_MOD2_BIT  = 1;

  // Values after reset
  localparam logic [1:0] OD_RST  = 2'h0;
  localparam logic [2:0] PAD_RST = 3'h0;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LAT_RST = 8'h00;

  // Clock pin source select
  typedef enum logic [1:0] {
    CLK_ALARM    = 2'h0,
    CLK_SECONDS  = 2'h1,
    CLK_SOURCE   = 2'h2,
    CLK_RESERVED = 2'h3
  } ppc_clk_sel_t;

  // Open-drain owner codes of a pin; bit k-1 of the enable vector serves code k
  localparam logic [2:0] OD_NONE = 3'h0;
  localparam logic [2:0] OD_CAP1 = 3'h1;
  localparam logic [2:0] OD_CAP2 = 3'h2;
  localparam logic [2:0] OD_SER1 = 3'h3;
  localparam logic [2:0] OD_SER2 = 3'h4;
  localparam logic [2:0] OD_SPI1 = 3'h5;
  localparam logic [2:0] OD_SPI2 = 3'h6;

  // Per-pin request of the peripheral that shares the pin
  typedef struct packed {
    logic       en;
    logic       out;
    logic       oe;
    logic [2:0] od_src;
  } ppc_periph_t;

  // Open-drain is active only for a pin owned by one of the six capable outputs
  function automatic logic ppc_od_active(input logic [2:0] src, input logic [5:0] vec);
    logic r;
    r = 1'b0;
    if (src != OD_NONE && src != 3'h7) begin
      r = vec[src - 3'h1];
    end
    return r;
  endfunction : ppc_od_active

  // True when an index falls inside a bank of per-port registers
  function automatic logic ppc_bank_hit(input logic [11:0] idx, input logic [11:0] base);
    return (idx >= base) && (idx < base + 12'(NUM_PORTS));
  endfunction : ppc_bank_hit

  // Port number inside a bank
  function automatic logic [2:0] ppc_bank_num(input logic [11:0] idx, input logic [11:0] base);
    logic [11:0] d;
    d = idx - base;
    return d[2:0];
  endfunction : ppc_bank_num

endpackage : ppc_pkg

// [rtl/ppc_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels
module ppc_sync
  import ppc_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : ppc_sync

// [rtl/ppc_port.sv]
`timescale 1ns/1ps
// One 8-bit port: direction, latch and pin drivers
module ppc_port
  import ppc_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // Register writes
  input  wire logic                      dir_we_i,
  input  wire logic                      lat_we_i,
  input  wire logic [PORT_W-1:0]         wdata_i,
  input  wire logic [5:0]                od_vec_i,
  // Peripherals sharing the pins
  input  wire ppc_periph_t [PORT_W-1:0]  periph_i,
  // Register state
  output logic        [PORT_W-1:0]       dir_o,
  output logic        [PORT_W-1:0]       lat_o,
  // Pin drivers
  output logic        [PORT_W-1:0]       pin_o,
  output logic        [PORT_W-1:0]       pin_oe_o
);

  logic [PORT_W-1:0] next_pin;
  logic [PORT_W-1:0] next_oe;

  // Direction and latch hold the software view of the port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_o <= DIR_RST;
      lat_o <= LAT_RST;
    end else if (ce_i) begin
      if (dir_we_i) dir_o <= wdata_i;
      if (lat_we_i) lat_o <= wdata_i;
    end
  end

  // Per-pin driver selection
  for (genvar b = 0; b < PORT_W; b++) begin : g_bit
    wire od_on   = periph_i[b].en && ppc_od_active(periph_i[b].od_src, od_vec_i);
    wire drv     = periph_i[b].en ? periph_i[b].oe  : ~dir_o[b];
    wire val     = periph_i[b].en ? periph_i[b].out : lat_o[b];
    // Open-drain only ever pulls low, so a high is left to the pull-up
    assign next_oe[b]  = od_on ? (drv & ~val) : drv;
    assign next_pin[b] = od_on ? 1'b0 : val;
  end

  // Registered pin drivers keep glitches off the pads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else if (ce_i) begin
      pin_o    <= next_pin;
      pin_oe_o <= next_oe;
    end
  end

endmodule : ppc_port

// [rtl/ppc_top.sv]
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
// GPIO ports with pad configuration behind a classic Wishbone slave
module ppc_top
  import ppc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [13:0]              wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Port pins
  input  wire logic [PIN_W-1:0]         pin_i,
  output logic      [PIN_W-1:0]         pin_o,
  output logic      [PIN_W-1:0]         pin_oe_o,
  // Peripherals sharing port pins
  input  wire ppc_periph_t [PIN_W-1:0]  periph_i,
  // Pad configuration outputs
  output logic      [1:0]               capture_open_drain_en_o,
  output logic      [1:0]               serial_open_drain_en_o,
  output logic      [1:0]               spi_open_drain_en_o,
  output logic                          parallel_port_ttl_sel_o,
  // Real-time clock pin
  input  wire logic                     rtc_alarm_pulse_i,
  input  wire logic                     rtc_seconds_clk_i,
  input  wire logic                     rtc_source_clk_i,
  input  wire logic                     clock_pin_output_en_i,
  output logic                          rtc_pin_o,
  output logic                          rtc_pin_oe_o
);

  // Configuration registers
  logic [1:0]          od_cap;
  logic [1:0]          od_ser;
  logic [1:0]          od_spi;
  logic [2:0]          pad_cfg;
  logic [PIN_W-1:0]    pin_lvl;
  logic [PORT_W-1:0]   dir_q [NUM_PORTS];
  logic [PORT_W-1:0]   lat_q [NUM_PORTS];

  // Address decode
  wire [11:0] idx      = wb_adr_i[13:2];
  wire        req      = wb_cyc_i & wb_stb_i;
  wire        hit_pad  = (idx == IDX_PAD);
  wire        hit_spi  = (idx == IDX_OD_SPI);
  wire        hit_ser  = (idx == IDX_OD_SER);
  wire        hit_cap  = (idx == IDX_OD_CAP);
  wire        hit_pin  = ppc_bank_hit(idx, IDX_PIN_BASE);
  wire        hit_lat  = ppc_bank_hit(idx, IDX_LAT_BASE);
  wire        hit_dir  = ppc_bank_hit(idx, IDX_DIR_BASE);
  wire [2:0]  num_pin  = ppc_bank_num(idx, IDX_PIN_BASE);
  wire [2:0]  num_lat  = ppc_bank_num(idx, IDX_LAT_BASE);
  wire [2:0]  num_dir  = ppc_bank_num(idx, IDX_DIR_BASE);

  // A write lands on the edge where the master sees ack; only lane 0 carries data
  wire        wr_stb   = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [7:0]  wbyte    = wb_dat_i[7:0];
  wire [5:0]  od_vec   = {od_spi, od_ser, od_cap};
  wire ppc_clk_sel_t clk_sel = ppc_clk_sel_t'(pad_cfg[CLK_SEL_MSB:CLK_SEL_LSB]);

  // Read selection; unmapped indices and unimplemented bits read zero
  wire [7:0] rd_cfg  = hit_pad ? {5'h00, pad_cfg} :
                       hit_spi ? {6'h00, od_spi}  :
                       hit_ser ? {6'h00, od_ser}  :
                       hit_cap ? {6'h00, od_cap}  : 8'h00;
  wire [7:0] rd_port = hit_pin ? pin_lvl[num_pin*PORT_W +: PORT_W] :
                       hit_lat ? lat_q[num_lat] :
                       hit_dir ? dir_q[num_dir] : 8'h00;
  wire [7:0] rd_byte = rd_cfg | rd_port;

  // Bus handshake: one wait state, ack for exactly one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Open-drain and pad configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      od_cap  <= OD_RST;
      od_ser  <= OD_RST;
      od_spi  <= OD_RST;
      pad_cfg <= PAD_RST;
    end else if (ce_i && wr_stb) begin
      if (hit_cap) od_cap  <= wbyte[OD_MOD2_BIT:OD_MOD1_BIT];
      if (hit_ser) od_ser  <= wbyte[OD_MOD2_BIT:OD_MOD1_BIT];
      if (hit_spi) od_spi  <= wbyte[OD_MOD2_BIT:OD_MOD1_BIT];
      if (hit_pad) pad_cfg <= wbyte[CLK_SEL_MSB:PAD_TTL_BIT];
    end
  end

  // Configuration outputs follow the registers directly
  assign capture_open_drain_en_o = od_cap;
  assign serial_open_drain_en_o  = od_ser;
  assign spi_open_drain_en_o     = od_spi;
  assign parallel_port_ttl_sel_o = pad_cfg[PAD_TTL_BIT];

  // Pin levels come from outside the clock domain
  ppc_sync #(
    .W (PIN_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pin_i),
    .q_o   (pin_lvl)
  );

  // One port instance per register bank slot
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    // Writing either the pin-level or latch index stores into the latch
    wire lat_we = wr_stb & ((hit_lat & num_lat == 3'(p)) | (hit_pin & num_pin == 3'(p)));
    wire dir_we = wr_stb & hit_dir & (num_dir == 3'(p));
    ppc_port u_port (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .dir_we_i (dir_we),
      .lat_we_i (lat_we),
      .wdata_i  (wbyte),
      .od_vec_i (od_vec),
      .periph_i (periph_i[p*PORT_W +: PORT_W]),
      .dir_o    (dir_q[p]),
      .lat_o    (lat_q[p]),
      .pin_o    (pin_o[p*PORT_W +: PORT_W]),
      .pin_oe_o (pin_oe_o[p*PORT_W +: PORT_W])
    );
  end

  // Clock pin source; the reserved code drives nothing rather than guess
  wire rtc_src = (clk_sel == CLK_ALARM)   ? rtc_alarm_pulse_i :
                 (clk_sel == CLK_SECONDS) ? rtc_seconds_clk_i :
                 (clk_sel == CLK_SOURCE)  ? rtc_source_clk_i  : 1'b0;
  wire rtc_en  = clock_pin_output_en_i & (clk_sel != CLK_RESERVED);

  // Registered clock pin so its output is glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rtc_pin_o    <= 1'b0;
      rtc_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      rtc_pin_o    <= rtc_en & rtc_src;
      rtc_pin_oe_o <= rtc_en;
    end
  end

  // Checks on the block's outputs and its internal register state
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A request taken by the slave in its first cycle
  sequence s_bus_take;
    ce_i && req && !wb_ack_o;
  endsequence

  // Writes that land on each configuration register
  sequence s_cap_write;
    ce_i && wr_stb && hit_cap;
  endsequence

  sequence s_ser_write;
    ce_i && wr_stb && hit_ser;
  endsequence

  sequence s_spi_write;
    ce_i && wr_stb && hit_spi;
  endsequence

  sequence s_pad_write;
    ce_i && wr_stb && hit_pad;
  endsequence

  // Clock pin sources chosen while the pin is enabled
  sequence s_alarm_sel;
    ce_i && clock_pin_output_en_i && clk_sel == CLK_ALARM;
  endsequence

  sequence s_seconds_sel;
    ce_i && clock_pin_output_en_i && clk_sel == CLK_SECONDS;
  endsequence

  sequence s_source_sel;
    ce_i && clock_pin_output_en_i && clk_sel == CLK_SOURCE;
  endsequence

  // Answer one edge after the take, then drop; a frozen clock enable holds ack
  a_bus_ack_next: assert property (
    s_bus_take |=> wb_ack_o)
    else $error("request not acknowledged");

  a_bus_ack_pulse: assert property (
    (ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // Unimplemented bits and unmapped indices read zero
  a_od_read_zero: assert property (
    (wb_ack_o && (hit_cap || hit_ser || hit_spi)) |-> wb_dat_o[31:2] == 30'h0)
    else $error("open-drain register upper bits not zero");

  a_pad_read_zero: assert property (
    (wb_ack_o && hit_pad) |-> wb_dat_o[31:3] == 29'h0)
    else $error("pad register upper bits not zero");

  a_unmapped_zero: assert property (
    s_bus_take ##0 !(hit_pad || hit_spi || hit_ser || hit_cap || hit_pin || hit_lat || hit_dir)
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped index did not read zero");

  // Read data of the port banks, watched on port 1
  a_latch_readback: assert property (
    s_bus_take ##0 (hit_lat && num_lat == 3'h1)
    |=> (wb_ack_o && wb_dat_o[7:0] == $past(lat_q[1])))
    else $error("latch read did not return latch value");

  a_pin_readback: assert property (
    s_bus_take ##0 (hit_pin && num_pin == 3'h1) |=> wb_dat_o[7:0] == $past(pin_lvl[15:8]))
    else $error("pin-level read did not return pin levels");

  a_dir_readback: assert property (
    s_bus_take ##0 (hit_dir && num_dir == 3'h1) |=> wb_dat_o[7:0] == $past(dir_q[1]))
    else $error("direction read did not return direction");

  // Configuration writes land on the ack edge
  a_cap_write_bits: assert property (
    s_cap_write |=> od_cap == $past(wb_dat_i[1:0]))
    else $error("capture open-drain bits not written");

  a_ser_write_bits: assert property (
    s_ser_write |=> serial_open_drain_en_o == $past(wb_dat_i[1:0]))
    else $error("serial open-drain bits not written");

  a_spi_write_bits: assert property (
    s_spi_write |=> spi_open_drain_en_o == $past(wb_dat_i[1:0]))
    else $error("SPI open-drain bits not written");

  a_ttl_write: assert property (
    s_pad_write |=> parallel_port_ttl_sel_o == $past(wb_dat_i[PAD_TTL_BIT]))
    else $error("input buffer select not written");

  a_clk_sel_write: assert property (
    s_pad_write |=> pad_cfg[CLK_SEL_MSB:CLK_SEL_LSB] == $past(wb_dat_i[2:1]))
    else $error("clock pin select not written");

  // Without a landing write the configuration holds
  a_cap_hold: assert property (
    (ce_i && !(wr_stb && hit_cap)) |=> $stable(od_cap))
    else $error("capture open-drain bits changed without a write");

  a_pad_hold: assert property (
    (ce_i && !(wr_stb && hit_pad)) |=> $stable(pad_cfg))
    else $error("pad configuration changed without a write");

  // Reset leaves every configuration bit clear
  a_od_reset_clear: assert property (
    $fell(rst_i) |-> (od_vec == 6'h00 && pad_cfg == 3'h0))
    else $error("configuration not clear after reset");

  // Software view of port 1 reaching its pins
  a_pin_write_latch: assert property (
    (ce_i && wr_stb && hit_pin && num_pin == 3'h1) |=> lat_q[1] == $past(wbyte))
    else $error("pin-level write did not reach latch");

  a_dir_write: assert property (
    (ce_i && wr_stb && hit_dir && num_dir == 3'h1) |=> dir_q[1] == $past(wbyte))
    else $error("direction write did not land");

  a_dir_release: assert property (
    (ce_i && !periph_i[12].en && dir_q[1][4]) |=> !pin_oe_o[12])
    else $error("input pin still driven");

  a_lat_drive: assert property (
    (ce_i && !periph_i[8].en && !dir_q[1][0])
    |=> (pin_oe_o[8] && pin_o[8] == $past(lat_q[1][0])))
    else $error("output pin not driving its latch");

  // Peripheral ownership and open-drain, watched on pin 16
  a_periph_takeover: assert property (
    (ce_i && periph_i[16].en && !ppc_od_active(periph_i[16].od_src, od_vec))
    |=> (pin_o[16] == $past(periph_i[16].out) && pin_oe_o[16] == $past(periph_i[16].oe)))
    else $error("peripheral did not own its pin");

  a_od_high_release: assert property (
    (ce_i && periph_i[16].en && periph_i[16].out
     && ppc_od_active(periph_i[16].od_src, od_vec)) |=> (!pin_oe_o[16] && !pin_o[16]))
    else $error("open-drain high was driven");

  a_od_low_drive: assert property (
    (ce_i && periph_i[16].en && periph_i[16].oe && !periph_i[16].out
     && ppc_od_active(periph_i[16].od_src, od_vec)) |=> (pin_oe_o[16] && !pin_o[16]))
    else $error("open-drain low was not driven");

  a_od_cap1_off: assert property (
    (ce_i && periph_i[16].en && periph_i[16].od_src == OD_CAP1 && !od_cap[OD_MOD1_BIT])
    |=> pin_o[16] == $past(periph_i[16].out))
    else $error("disabled capture open-drain still applied");

  // Clock pin follows its select only while enabled
  a_rtc_gate: assert property (
    (ce_i && !clock_pin_output_en_i) |=> (!rtc_pin_oe_o && !rtc_pin_o))
    else $error("clock pin driven without output enable");

  a_rtc_alarm: assert property (
    s_alarm_sel |=> (rtc_pin_oe_o && rtc_pin_o == $past(rtc_alarm_pulse_i)))
    else $error("clock pin did not carry alarm pulse");

  a_rtc_seconds: assert property (
    s_seconds_sel |=> (rtc_pin_oe_o && rtc_pin_o == $past(rtc_seconds_clk_i)))
    else $error("clock pin did not carry seconds clock");

  a_rtc_source: assert property (
    s_source_sel |=> (rtc_pin_oe_o && rtc_pin_o == $past(rtc_source_clk_i)))
    else $error("clock pin did not carry source clock");

  a_rtc_reserved: assert property (
    (ce_i && clk_sel == CLK_RESERVED) |=> (!rtc_pin_oe_o && !rtc_pin_o))
    else $error("clock pin driven with reserved select");

endmodule : ppc_top

// [sim/ppc_pin_model.sv]
`timescale 1ns/1ps
// Board around the port pins: pull-ups plus outside logic that may drive a line
module ppc_pin_model
  import ppc_pkg::*;
(
  // Design side
  input  wire logic [PIN_W-1:0] pin_o,
  input  wire logic [PIN_W-1:0] pin_oe_o,
  // Outside logic
  input  wire logic [PIN_W-1:0] ext_en_i,
  input  wire logic [PIN_W-1:0] ext_val_i,
  // Resolved levels seen by the design
  output logic      [PIN_W-1:0] pin_i
);
  // Released lines with no outside driver float up through the pull-up, never to the last driven value
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
               | (~pin_oe_o & ~ext_en_i);
endmodule : ppc_pin_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
// Self-checking bench for the port and pad configuration block
module tb_top
  import ppc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack;
  logic [PIN_W-1:0] pin_i, pin_o, pin_oe, ext_en = '0, ext_val = '0;
  ppc_periph_t [PIN_W-1:0] periph = '0;
  logic [1:0] od_cap, od_ser, od_spi;
  logic ttl, alarm = 1'b0, secs = 1'b0, srcclk = 1'b0, rtc_en = 1'b0, rtc_pin, rtc_oe;
  int bad_count = 0, cmp_count = 0, cyc_cnt = 0;

  // Clock at 40 MHz
  initial forever #12.5 clk_i = ~clk_i;

  ppc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .periph_i(periph),
    .capture_open_drain_en_o(od_cap), .serial_open_drain_en_o(od_ser),
    .spi_open_drain_en_o(od_spi), .parallel_port_ttl_sel_o(ttl),
    .rtc_alarm_pulse_i(alarm), .rtc_seconds_clk_i(secs), .rtc_source_clk_i(srcclk),
    .clock_pin_output_en_i(rtc_en), .rtc_pin_o(rtc_pin), .rtc_pin_oe_o(rtc_oe));

  ppc_pin_model u_pins (.pin_o(pin_o), .pin_oe_o(pin_oe), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_i(pin_i));

  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // One classic cycle; request held until ack is sampled, then released
  task automatic xfer(input logic [11:0] idx, input logic w, input logic [7:0] d,
                      input logic [3:0] s);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'h0};
    wdat <= {24'h0, d};
    sel  <= s;
    // No limit of its own: a lost answer is ended by the hang guard
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d, 4'h1);
  endtask : wr

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] e);
    xfer(idx, 1'b0, 8'h00, 4'hF);
    `CHK(q, {24'h0, e})
  endtask : rd_chk

  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask : settle

  // Values right after reset
  task automatic t_reset_vals();
    rd_chk(IDX_PAD, 8'h00);
    rd_chk(IDX_OD_SPI, 8'h00);
    rd_chk(IDX_OD_SER, 8'h00);
    rd_chk(IDX_OD_CAP, 8'h00);
    rd_chk(IDX_DIR_BASE + 12'h001, DIR_RST);
    rd_chk(IDX_LAT_BASE + 12'h001, LAT_RST);
  endtask : t_reset_vals

  // Implemented bits, reserved bits and per-bit mapping of the config registers
  task automatic t_cfg_regs();
    xfer(IDX_PAD, 1'b1, 8'hFF, 4'h0);
    rd_chk(IDX_PAD, 8'h00);
    wr(IDX_PAD, 8'hFF);
    wr(IDX_OD_SPI, 8'hFF);
    wr(IDX_OD_SER, 8'hFF);
    wr(IDX_OD_CAP, 8'hFF);
    rd_chk(IDX_PAD, 8'h07);
    rd_chk(IDX_OD_SPI, 8'h03);
    rd_chk(IDX_OD_SER, 8'h03);
    rd_chk(IDX_OD_CAP, 8'h03);
    `CHK(ttl, 1'b1)
    wr(IDX_PAD, 8'hFE);
    wr(IDX_OD_CAP, 8'h02);
    wr(IDX_OD_SER, 8'h01);
    wr(IDX_OD_SPI, 8'h02);
    // The last write lands on the edge the task returns at
    settle();
    `CHK(ttl, 1'b0)
    `CHK(od_cap, 2'h2)
    `CHK(od_ser, 2'h1)
    `CHK(od_spi, 2'h2)
    wr(12'h010, 8'h5A);
    rd_chk(12'h010, 8'h00);
  endtask : t_cfg_regs

  // Direction writes, latch and pin-level reads on port 1
  task automatic t_gpio();
    wr(IDX_DIR_BASE + 12'h001, 8'h00);
    wr(IDX_PIN_BASE + 12'h001, 8'hA5);
    settle();
    `CHK(pin_oe[15:8], 8'hFF)
    `CHK(pin_o[15:8], 8'hA5)
    rd_chk(IDX_LAT_BASE + 12'h001, 8'hA5);
    rd_chk(IDX_PIN_BASE + 12'h001, 8'hA5);
    ext_en[15:8] <= 8'hFF;
    ext_val[15:8] <= 8'h3C;
    wr(IDX_DIR_BASE + 12'h001, 8'hF0);
    settle();
    `CHK(pin_oe[15:8], 8'h0F)
    rd_chk(IDX_PIN_BASE + 12'h001, 8'h35);
    rd_chk(IDX_LAT_BASE + 12'h001, 8'hA5);
  endtask : t_gpio

  // Peripheral takeover of a pin and open-drain for each capable output
  task automatic t_periph_od();
    wr(IDX_OD_SPI, 8'h03);
    wr(IDX_OD_SER, 8'h03);
    wr(IDX_OD_CAP, 8'h03);
    for (int k = 1; k <= 6; k++) begin
      periph[16] <= '{1'b1, 1'b1, 1'b1, 3'(k)};
      settle();
      `CHK(pin_oe[16], 1'b0)
      periph[16] <= '{1'b1, 1'b0, 1'b1, 3'(k)};
      settle();
      `CHK({pin_oe[16], pin_o[16]}, 2'h2)
    end
    periph[16] <= '{1'b1, 1'b1, 1'b1, OD_NONE};
    settle();
    `CHK({pin_oe[16], pin_o[16]}, 2'h3)
    wr(IDX_OD_CAP, 8'h02);
    periph[16] <= '{1'b1, 1'b1, 1'b1, OD_CAP1};
    settle();
    `CHK({pin_oe[16], pin_o[16]}, 2'h3)
    periph[16] <= '{1'b1, 1'b1, 1'b1, OD_CAP2};
    settle();
    `CHK(pin_oe[16], 1'b0)
    periph[16] <= '0;
  endtask : t_periph_od

  // Clock pin source select against the module's output enable
  task automatic t_rtc_pin();
    logic [2:0] hot;
    logic eo;
    for (int s = 0; s < 4; s++) begin
      wr(IDX_PAD, 8'(s << 1));
      for (int e = 0; e < 2; e++) begin
        for (int v = 0; v < 2; v++) begin
          hot = (s < 3) ? 3'(1 << s) : 3'h0;
          if (v == 1) hot = ~hot;
          alarm <= hot[0];
          secs <= hot[1];
          srcclk <= hot[2];
          rtc_en <= e[0];
          settle();
          eo = (e == 1) && (s != 3);
          `CHK(rtc_oe, eo)
          `CHK(rtc_pin, eo && (v == 0))
        end
      end
    end
  endtask : t_rtc_pin

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_cfg_regs();
    t_gpio();
    t_periph_od();
    t_rtc_pin();
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    wrap_up();
  end
endmodule : tb_top
